// [core/swh_pkg.sv]
package swh_pkg;
  // =========================================================
  // control word codes
  localparam logic [15:0] CW_ENABLE = 16'h0001;
  localparam logic [15:0] CW_PAUSE = 16'h0002;
  localparam logic [15:0] CW_CONTINUE = 16'h0003;
  localparam logic [15:0] CW_ESTOP = 16'h0004;
  localparam logic [15:0] CW_CSTOP = 16'h0005;
  localparam logic [15:0] CW_STEPDIR = 16'h0006;
  localparam logic [15:0] CW_TWOPULSE = 16'h0007;
  // =========================================================
  // status word bit positions
  localparam int ST_ENABLED = 0;
  localparam int ST_PAUSED = 1;
  localparam int ST_QEMPTY = 3;
  localparam int ST_PENDING = 5;
  localparam logic [15:0] STATUS_RESET = 16'h0008;
  // =========================================================
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int PROC_TIME_US = 3000;
  localparam int PROC_CYCLES = CLK_HZ / 1000000 * PROC_TIME_US;
  localparam int PROC_DEFAULT = 64;
  // =========================================================
  typedef enum logic [1:0] {MOVE_NONE, MOVE_DIST, MOVE_VEL} swh_move_e;
  typedef enum {S_IDLE, S_WAIT, S_EXEC} swh_state_e;
  typedef struct packed {
    logic start;
    swh_move_e kind;
    logic dir;
  } swh_cmd_s;
endpackage : swh_pkg

// [core/swh_stepper_control_word_handler.sv]
`timescale 1ns/1ps
// What this block does
// RULE1 - profile commands are only taken into the queue once the enable word has been seen.
// RULE2 - a pause word stops further queued commands from starting until continue arrives.
// RULE3 - while paused, a distance or position move already running finishes normally.
// RULE4 - a continue word clears paused and advances to the next queued command.
// RULE5 - continue during an unfinished command aborts it and starts the next one.
// RULE6 - continue on a lone velocity move sets queue empty at once and ramps down.
// RULE7 - emergency stop halts step pulses at once and flushes the queue.
// RULE8 - controlled stop aborts the move, ramps down at the current rate and flushes.
// RULE9 - word 6 selects step plus direction output, which is also the reset mode.
// RULE10 - word 7 selects forward steps on output one and reverse steps on output two.
// RULE11 - a word may take up to the processing time and the host waits for pending clear.
// RULE12 - enabled bit is set by enable and cleared by estop, finished cstop or bad word.
// RULE13 - paused bit is set by pause or a velocity move and cleared by continue.
// RULE14 - pending bit holds from the word write until processing is done.
// RULE15 - queue empty sets when the last command completes and clears on a new entry.
// RULE16 - codes outside one to seven are illegal; they disable the profile, abort the move and flush the queue.
module swh_stepper_control_word_handler
  import swh_pkg::*;
#(
  parameter int PROC_CYCLES_P = PROC_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cw_write,
  input wire logic [15:0] control_word_number,
  input wire swh_cmd_s cmd_in,
  output logic cmd_accept,
  input wire logic [1:0] queue_count,
  output logic queue_pop,
  output logic queue_flush,
  output swh_cmd_s active_cmd_q,
  output logic move_abort,
  output logic ramp_down_q,
  input wire logic move_done,
  input wire logic motor_stopped,
  input wire logic step_tick,
  output logic [15:0] status_word,
  output logic out1_q,
  output logic out2_q
);
  // =========================================================
  // control state
  logic enabled_q, enabled_d, paused_q, paused_d, qempty_q, qempty_d;
  logic pending_q, pending_d, twopulse_q, twopulse_d, ramp_down_d, cstop_q, cstop_d;
  logic running_q, running_d;
  logic [15:0] word_q, word_d;
  logic [31:0] cnt_q, cnt_d;
  swh_cmd_s active_cmd_d;
  logic out1_d, out2_d;

  // accept commands only while enabled [RULE1]
  assign cmd_accept = enabled_q && cmd_in.start; // [RULE1]

  // status word assembly
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_ENABLED] = enabled_q; // [RULE12]
    status_word[ST_PAUSED] = paused_q; // [RULE13]
    status_word[ST_QEMPTY] = qempty_q; // [RULE15]
    status_word[ST_PENDING] = pending_q; // [RULE14]
  end

  // =========================================================
  // next state: control words, queue advance, move tracking
  // the word is latched at the write and only acted on when the
  // processing count runs out, so the host sees the pending bit for
  // the whole window and a second write inside it is simply dropped.
  // flush and abort are single-cycle strobes; the queue and the move
  // generator outside must act on them in the cycle they appear.
  // stop handling wins over starting a new command, so a stop word
  // can never leave a freshly popped command running.
  always_comb begin
    enabled_d = enabled_q;
    paused_d = paused_q;
    qempty_d = qempty_q;
    pending_d = pending_q;
    twopulse_d = twopulse_q;
    ramp_down_d = ramp_down_q;
    cstop_d = cstop_q;
    running_d = running_q;
    word_d = word_q;
    cnt_d = cnt_q;
    active_cmd_d = active_cmd_q;
    queue_pop = 1'b0;
    queue_flush = 1'b0;
    move_abort = 1'b0;
    // new entry clears empty; set below wins on same cycle
    if (cmd_accept) begin
      qempty_d = 1'b0; // [RULE15]
    end
    // latch the word, then hold pending over the processing time
    if (cw_write && !pending_q) begin
      word_d = control_word_number;
      pending_d = 1'b1; // [RULE14]
      cnt_d = 32'(PROC_CYCLES_P - 1); // [RULE11]
    end else if (pending_q && cnt_q != 32'h0000_0000) begin
      cnt_d = cnt_q - 32'h0000_0001; // [RULE11]
    end else if (pending_q) begin
      pending_d = 1'b0; // [RULE14]
      case (word_q)
        CW_ENABLE: enabled_d = 1'b1; // [RULE1]
        CW_PAUSE: paused_d = 1'b1; // [RULE2] [RULE13]
        CW_CONTINUE: begin
          paused_d = 1'b0; // [RULE4] [RULE13]
          if (running_q) begin
            move_abort = 1'b1; // [RULE5]
            running_d = 1'b0;
            if (queue_count == 2'd0) begin
              qempty_d = 1'b1; // [RULE6]
              ramp_down_d = active_cmd_q.kind == MOVE_VEL; // [RULE6]
            end
          end
        end
        CW_ESTOP: begin
          enabled_d = 1'b0; // [RULE7] [RULE12]
          queue_flush = 1'b1; // [RULE7]
          move_abort = 1'b1; // [RULE7]
          running_d = 1'b0;
          ramp_down_d = 1'b0;
          qempty_d = 1'b1;
        end
        CW_CSTOP: begin
          move_abort = 1'b1; // [RULE8]
          queue_flush = 1'b1; // [RULE8]
          running_d = 1'b0;
          ramp_down_d = 1'b1; // [RULE8]
          cstop_d = 1'b1;
          qempty_d = 1'b1;
        end
        CW_STEPDIR: twopulse_d = 1'b0; // [RULE9]
        CW_TWOPULSE: twopulse_d = 1'b1; // [RULE10]
        default: begin
          enabled_d = 1'b0; // [RULE16] [RULE12]
          queue_flush = 1'b1; // an illegal word empties the queue as well as disabling
          move_abort = 1'b1;
          running_d = 1'b0;
          qempty_d = 1'b1;
        end
      endcase
    end
    // finished controlled stop drops the enable
    if (cstop_q && motor_stopped) begin
      cstop_d = 1'b0;
      ramp_down_d = 1'b0;
      enabled_d = 1'b0; // [RULE12]
    end else if (ramp_down_q && !cstop_q && motor_stopped) begin
      ramp_down_d = 1'b0; // [RULE6]
    end
    // running move ends on its own even while paused [RULE3]
    if (running_q && move_done && !move_abort) begin
      running_d = 1'b0; // [RULE3]
      if (queue_count == 2'd0) begin
        qempty_d = 1'b1; // [RULE15]
      end
    end
    // start next queued command unless paused or stopping [RULE2]
    if (!running_d && !paused_d && enabled_d && !queue_flush && !cstop_d
        && queue_count != 2'd0) begin
      queue_pop = 1'b1; // [RULE4]
      running_d = 1'b1;
      ramp_down_d = 1'b0;
      active_cmd_d = cmd_in;
      if (cmd_in.kind == MOVE_VEL) begin
        paused_d = 1'b1; // [RULE13]
      end
    end
  end

  // =========================================================
  // pulse encoding: estop or disabled kills pulses at once [RULE7]
  // direction level low means forward in both encodings
  always_comb begin
    out1_d = 1'b0;
    out2_d = 1'b0;
    if (enabled_q && (running_q || ramp_down_q)) begin
      if (twopulse_q) begin
        out1_d = step_tick && !active_cmd_q.dir; // [RULE10]
        out2_d = step_tick && active_cmd_q.dir; // [RULE10]
      end else begin
        out1_d = step_tick; // [RULE9]
        out2_d = active_cmd_q.dir; // [RULE9]
      end
    end else if (!twopulse_q) begin
      out2_d = active_cmd_q.dir;
    end
  end

  // =========================================================
  // registers; step/direction is the reset mode
  // every status bit and the out1_q, out2_q, ramp_down_q and active_cmd_q outputs come straight from a flop here, so the
  // host never samples a glitch while the next-state logic settles.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enabled_q <= STATUS_RESET[ST_ENABLED];
      paused_q <= STATUS_RESET[ST_PAUSED];
      qempty_q <= STATUS_RESET[ST_QEMPTY];
      pending_q <= STATUS_RESET[ST_PENDING];
      twopulse_q <= 1'b0; // [RULE9]
      ramp_down_q <= 1'b0;
      cstop_q <= 1'b0;
      running_q <= 1'b0;
      word_q <= 16'h0000;
      cnt_q <= 32'h0000_0000;
      active_cmd_q <= '0;
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      enabled_q <= enabled_d;
      paused_q <= paused_d;
      qempty_q <= qempty_d;
      pending_q <= pending_d;
      twopulse_q <= twopulse_d;
      ramp_down_q <= ramp_down_d;
      cstop_q <= cstop_d;
      running_q <= running_d;
      word_q <= word_d;
      cnt_q <= cnt_d;
      active_cmd_q <= active_cmd_d;
      out1_q <= out1_d;
      out2_q <= out2_d;
    end
  end
endmodule : swh_stepper_control_word_handler

// [dv/swh_monitor.sv]
`timescale 1ns/1ps
// ====
// port checker
module swh_monitor
  import swh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cw_write,
  input wire logic [15:0] control_word_number,
  input wire swh_cmd_s cmd_in,
  input wire logic cmd_accept,
  input wire logic queue_flush,
  input wire logic [15:0] status_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic [15:0] c;
  // a write only counts while nothing is pending
  assign tk = cw_write && !status_word[ST_PENDING];
  assign c = control_word_number;
  pend_rise_a: assert property (
    tk |=> status_word[ST_PENDING]) else $error("pending not raised");
  pend_hold_a: assert property (
    $rose(status_word[ST_PENDING]) |-> status_word[ST_PENDING][*3]) else $error("pending short");
  en_set_a: assert property (
    tk && c == CW_ENABLE |-> ##[1:70] status_word[ST_ENABLED]) else $error("no enable");
  estop_flush_a: assert property (
    tk && c == CW_ESTOP |-> ##[1:70] queue_flush) else $error("no flush");
  pause_set_a: assert property (
    tk && c == CW_PAUSE |-> ##[1:70] status_word[ST_PAUSED]) else $error("no pause");
  cont_clear_a: assert property (
    tk && c == CW_CONTINUE |-> ##[1:70] !status_word[ST_PAUSED]) else $error("still paused");
  bad_word_a: assert property (
    tk && (c == 0 || c > 7) |-> ##[1:70] !status_word[ST_ENABLED]) else $error("bad kept");
  accept_gate_a: assert property (
    cmd_accept |-> status_word[ST_ENABLED] && cmd_in.start) else $error("early accept");
  cover property (tk && c == CW_ESTOP);
  cover property (cmd_accept);
  cover property (tk && c > 7);
endmodule : swh_monitor
bind swh_stepper_control_word_handler swh_monitor mon (.*);

// [dv/swh_partner.sv]
`timescale 1ns/1ps
// ====
// queue and move generator model
module swh_partner
  import swh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic cmd_accept,
  input wire logic queue_pop,
  input wire logic queue_flush,
  input wire logic move_abort,
  output swh_cmd_s cmd_in,
  output logic [1:0] queue_count,
  output logic move_done,
  output logic motor_stopped,
  output logic step_tick
);
  logic [2:0] run_q;
  // always offers a forward distance move; dir low is forward in the handler
  assign cmd_in = '{start: push, kind: MOVE_DIST, dir: 1'b0};
  assign move_done = run_q == 3'h1;
  assign motor_stopped = run_q == 3'h0;
  // flush beats a new entry, so a stop never leaves stale work
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      queue_count <= 2'h0;
      run_q <= 3'h0;
      step_tick <= 1'b0;
    end else begin
      step_tick <= !step_tick;
      if (queue_flush) queue_count <= 2'h0;
      else queue_count <= queue_count + 2'(cmd_accept) - 2'(queue_pop);
      if (queue_flush || move_abort) run_q <= 3'h0;
      else if (queue_pop) run_q <= 3'h6;
      else if (run_q != 3'h0) run_q <= run_q - 3'h1;
    end
  end
endmodule : swh_partner

// [dv/swh_stepper_control_word_handler_tb.sv]
`timescale 1ns/1ps
module swh_stepper_control_word_handler_tb;
  import swh_pkg::*;
  logic ref_clk, rst, cw_write, push, cmd_accept, queue_pop, queue_flush, move_abort;
  logic ramp_down_q, move_done, motor_stopped, step_tick, out1_q, out2_q;
  logic [15:0] control_word_number, status_word;
  logic [1:0] queue_count;
  swh_cmd_s cmd_in, active_cmd_q;
  int err_total, n_checks;
  logic o_prev;
  // code, status mask, expected bits
  logic [15:0] rows [6][3] = '{'{CW_STEPDIR, 16'h0001, 16'h0000},
    '{CW_ENABLE, 16'h0001, 16'h0001}, '{CW_PAUSE, 16'h0003, 16'h0003},
    '{CW_CONTINUE, 16'h0002, 16'h0000}, '{CW_TWOPULSE, 16'h0001, 16'h0001},
    '{CW_ESTOP, 16'h0001, 16'h0000}};
  swh_stepper_control_word_handler #(.PROC_CYCLES_P(4)) uut (.*);
  swh_partner far_end (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // write a word, optionally a second one while pending, then wait it out
  task automatic cw(input logic [15:0] c, input logic dbl);
    int n;
    @(posedge ref_clk);
    cw_write <= 1'b1;
    control_word_number <= c;
    if (dbl) begin
      @(posedge ref_clk);
      control_word_number <= CW_ESTOP;
    end
    @(posedge ref_clk);
    cw_write <= 1'b0;
    #1;
    for (n = 0; n < 100 && status_word[ST_PENDING] !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n == 100) begin
      err_total++;
      finish_test();
    end
  endtask : cw
  task automatic offer(input int k);
    @(posedge ref_clk);
    push <= 1'b1;
    repeat (k) @(posedge ref_clk);
    push <= 1'b0;
    #1;
  endtask : offer
  initial begin
    rst = 1'b1;
    cw_write = 1'b0;
    push = 1'b0;
    control_word_number = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(status_word, STATUS_RESET);
    chk({out1_q, out2_q}, 16'h0000);
    @(posedge ref_clk);
    push <= 1'b1;
    #1;
    chk(cmd_accept, 1'b0);
    push <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      cw(rows[i][0], 1'b0);
      chk(status_word & rows[i][1], rows[i][2]);
    end
    push <= 1'b0;
    cw(CW_ENABLE, 1'b1);
    chk(status_word[ST_ENABLED], 1'b1);
    offer(1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(status_word[ST_QEMPTY], 1'b0);
    o_prev = out1_q;
    chk(out2_q, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(out1_q ^ o_prev, 1'b1);
    repeat (12) @(posedge ref_clk);
    #1;
    chk(status_word[ST_QEMPTY], 1'b1);
    cw(CW_PAUSE, 1'b0);
    offer(2);
    chk(queue_count, 2'h2);
    cw(CW_ESTOP, 1'b0);
    chk(queue_count, 2'h0);
    chk(status_word[ST_ENABLED], 1'b0);
    cw(CW_ENABLE, 1'b0);
    cw(16'h0009, 1'b0);
    chk(status_word[ST_ENABLED], 1'b0);
    cw(CW_CONTINUE, 1'b0);
    cw(CW_STEPDIR, 1'b0);
    cw(CW_ENABLE, 1'b0);
    offer(1);
    repeat (2) @(posedge ref_clk);
    #1;
    o_prev = out1_q;
    chk(out2_q, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(out1_q ^ o_prev, 1'b1);
    cw(CW_CSTOP, 1'b0);
    chk(queue_count, 2'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(status_word[ST_ENABLED], 1'b0);
    finish_test();
  end
endmodule : swh_stepper_control_word_handler_tb
